// ### rtl/pic_pkg.sv
// Shared constants and types for the peripheral instruction cycle block.
// Assumes a single 125 MHz clock domain and word-aligned AHB-Lite access.
package pic_pkg;

    // Instruction word layout on the accumulator bus
    localparam int ACC_W       = 24;
    localparam int DEV_LSB     = 0;
    localparam int DEV_W       = 8;
    localparam int ADDR_LSB    = 8;
    localparam int ADDR_W      = 6;
    localparam int WR_BIT      = 16;
    localparam int STAT_LSB    = 20;
    localparam int STAT_W      = 4;
    localparam int STATION_W   = 13;
    localparam int XDL_W       = 16;

    // Arbitrary neutral device code for this tester interface
    localparam logic [7:0] DEVICE_CODE_DEF = 8'h5A;

    // One-hot phase lines from the host: T2, T3, T4, T5, T1
    localparam logic [4:0] PH_T2 = 5'h01;
    localparam logic [4:0] PH_T3 = 5'h02;
    localparam logic [4:0] PH_T4 = 5'h04;
    localparam logic [4:0] PH_T5 = 5'h08;
    localparam logic [4:0] PH_T1 = 5'h10;

    // Short register addresses reachable by single peripheral transfers
    localparam logic [5:0] SPU_MODE    = 6'h10;
    localparam logic [5:0] SPU_STATUS  = 6'h11;
    localparam logic [5:0] SPU_INSTR   = 6'h12;
    localparam logic [5:0] SPU_STATION = 6'h13;

    // AHB register byte offsets
    localparam logic [7:0] OFS_MODE    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_STATION = 8'h08;
    localparam logic [7:0] OFS_INSTR   = 8'h0C;
    localparam logic [7:0] OFS_XDL     = 8'h10;
    localparam logic [7:0] OFS_STATE   = 8'h14;

    // Field positions
    localparam int MODE_DMA    = 0;
    localparam int MODE_TRAP   = 1;
    localparam int STS_IRQ     = 0;
    localparam int STS_START   = 1;
    localparam int STS_PHERR   = 2;

    // Reset values and the status output-enable mask
    localparam logic [XDL_W-1:0]     XDL_DELAY_RST = 16'h0040;
    localparam logic [STATION_W-1:0] STATION_RST   = 13'h0000;
    localparam logic [ACC_W-1:0]     STAT_OE       = 24'hF00000;

    typedef enum logic [5:0] {
        ST_WAIT = 6'h01,
        ST_T2   = 6'h02,
        ST_T3   = 6'h04,
        ST_T4   = 6'h08,
        ST_T5   = 6'h10,
        ST_T1   = 6'h20
    } pic_state_t;

    typedef struct packed {
        logic [4:0]       phase;
        logic             psel;
        logic             prio;
        logic             power;
        logic             start;
        logic [ACC_W-1:0] acc;
    } pic_pins_t;

endpackage : pic_pkg

// ### rtl/pic_xdl.sv
// Execute delay loop: holds the tester busy for a programmed count.
// Assumes start is a one-cycle pulse on hclk.
`timescale 1ns/100ps
module pic_xdl #(
    parameter int W = 16
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         ce,
    input  wire logic         start,
    input  wire logic [W-1:0] delay,
    output logic              busy
);

    logic [W-1:0] count;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
            busy  <= 1'b0;
        end else if (ce) begin
            if (start) begin
                // A zero delay still gives one busy cycle
                count <= delay;
                busy  <= 1'b1;
            end else if (count != '0) begin
                count <= count - 1'b1;
            end else begin
                busy <= 1'b0;
            end
        end
    end

endmodule : pic_xdl

// ### rtl/pic_core.sv
// Tester-side peripheral interface for single peripheral transfers.
// Assumes host pins are asynchronous; registers on AHB-Lite, zero waits.
//
// What this block does
// - Cycle phases run T2, T3, T4, T5, T1, then back to T2.
// - Each single read or write transfer finishes within one cycle.
// - Register address logic clears at T2.
// - Select accepted only if bits 0-7 match device code; two match signals.
// - Device selected is match A AND peripheral select.
// - When selected without higher priority, drive status on bits 20-23 at T4.
// - Status bit 20 carries tester power good.
// - Selection yields exactly one bus direction enable.
// - Start button sets start request, held until host reads station control.
// - Only short-bus registers are reachable by single transfers.
// - Status bit 21 carries the DMA mode flag.
// - Status bit 22 carries the interrupt pending flag.
// - Status bit 23 carries the busy flag from the delay loop.
// - Data strobe at T5 only if T4 status showed tester available.
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
module pic_core #(
    parameter logic [7:0] DEVICE_CODE = pic_pkg::DEVICE_CODE_DEF
) (
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic                     ce,
    // AHB-Lite slave
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic                     hready,
    input  wire logic [31:0]              hwdata,
    output logic      [31:0]              hrdata,
    output logic                          hreadyout,
    output logic                          hresp,
    // Host and panel pins
    input  wire pic_pkg::pic_pins_t       host_pins,
    output logic [pic_pkg::ACC_W-1:0]     acc_bus_out,
    output logic [pic_pkg::ACC_W-1:0]     acc_bus_oe,
    output logic                          device_code_match_a,
    output logic                          device_code_match_b,
    output logic                          device_selected,
    output logic                          drive_toward_peripheral_bus,
    output logic                          drive_toward_accumulator_bus,
    output logic                          peripheral_data_strobe
);

    localparam int ACC_W = pic_pkg::ACC_W;

    pic_pkg::pic_pins_t  pins_meta;
    pic_pkg::pic_pins_t  pins_s;
    pic_pkg::pic_state_t state;
    pic_pkg::pic_state_t next_state;
    logic                order_err;
    logic                start_q;
    logic                is_write;
    logic                t4_avail;
    logic [5:0]          pend_addr;
    logic [5:0]          reg_addr;
    logic                addr_valid;
    logic                mode_dma;
    logic                mode_trap;
    logic                irq_pending;
    logic                start_request;
    logic                phase_err;
    logic [pic_pkg::STATION_W-1:0] station;
    logic [ACC_W-1:0]    instr;
    logic [pic_pkg::XDL_W-1:0] xdl_delay;
    logic                busy;
    logic                wr_pend;
    logic [7:0]          wr_ofs;

    function automatic logic spu_hit(input logic [5:0] addr, input logic [5:0] code);
        spu_hit = (addr == code);
    endfunction : spu_hit

    function automatic logic ahb_hit(input logic [7:0] ofs, input logic [7:0] code);
        ahb_hit = (ofs == code);
    endfunction : ahb_hit

    // Two-stage synchroniser on every host and panel pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_meta <= '0;
            pins_s    <= '0;
        end else if (ce) begin
            pins_meta <= host_pins;
            pins_s    <= pins_meta;
        end
    end

    // Phase tracker
    logic [4:0]          cur_code;
    logic [4:0]          nxt_code;
    pic_pkg::pic_state_t nxt_st;

    always_comb begin
        cur_code = pic_pkg::PH_T2;
        nxt_code = pic_pkg::PH_T3;
        nxt_st   = pic_pkg::ST_T3;
        case (state)
            pic_pkg::ST_T2: begin
                cur_code = pic_pkg::PH_T2;
                nxt_code = pic_pkg::PH_T3;
                nxt_st   = pic_pkg::ST_T3;
            end
            pic_pkg::ST_T3: begin
                cur_code = pic_pkg::PH_T3;
                nxt_code = pic_pkg::PH_T4;
                nxt_st   = pic_pkg::ST_T4;
            end
            pic_pkg::ST_T4: begin
                cur_code = pic_pkg::PH_T4;
                nxt_code = pic_pkg::PH_T5;
                nxt_st   = pic_pkg::ST_T5;
            end
            pic_pkg::ST_T5: begin
                cur_code = pic_pkg::PH_T5;
                nxt_code = pic_pkg::PH_T1;
                nxt_st   = pic_pkg::ST_T1;
            end
            pic_pkg::ST_T1: begin
                cur_code = pic_pkg::PH_T1;
                nxt_code = pic_pkg::PH_T2;
                nxt_st   = pic_pkg::ST_T2;
            end
            default: begin
                cur_code = pic_pkg::PH_T2;
                nxt_code = pic_pkg::PH_T2;
                nxt_st   = pic_pkg::ST_T2;
            end
        endcase
    end

    always_comb begin
        next_state = state;
        order_err  = 1'b0;
        if (state == pic_pkg::ST_WAIT) begin
            if (pins_s.phase == pic_pkg::PH_T2) begin
                next_state = pic_pkg::ST_T2;
            end
        end else if (pins_s.phase != cur_code && pins_s.phase != 5'h00) begin
            if (pins_s.phase == nxt_code) begin
                next_state = nxt_st;
            end else begin
                // Out-of-order phase: resynchronise on the next T2
                order_err  = 1'b1;
                next_state = pic_pkg::ST_WAIT;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= pic_pkg::ST_WAIT;
        end else if (ce) begin
            state <= next_state;
        end
    end

    logic enter;
    logic enter_t2;
    logic enter_t4;
    logic enter_t5;
    logic enter_t1;
    logic sel_now;
    logic spu_wr;
    logic spu_rd;

    assign enter    = ce && (next_state != state);
    assign enter_t2 = enter && (next_state == pic_pkg::ST_T2);
    assign enter_t4 = enter && (next_state == pic_pkg::ST_T4);
    assign enter_t5 = enter && (next_state == pic_pkg::ST_T5);
    assign enter_t1 = enter && (next_state == pic_pkg::ST_T1);

    // Both boards compare the same code independently
    assign device_code_match_a = (pins_s.acc[pic_pkg::DEV_LSB +: pic_pkg::DEV_W] == DEVICE_CODE);
    assign device_code_match_b = (pins_s.acc[pic_pkg::DEV_LSB +: pic_pkg::DEV_W] == DEVICE_CODE);
    assign sel_now = device_code_match_a && pins_s.psel;

    // Selection and transfer direction, latched at T4
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            device_selected <= 1'b0;
            is_write        <= 1'b0;
            pend_addr       <= '0;
            t4_avail        <= 1'b0;
        end else if (enter_t2) begin
            device_selected <= 1'b0;
            t4_avail        <= 1'b0;
        end else if (enter_t4) begin
            device_selected <= sel_now;
            is_write        <= pins_s.acc[pic_pkg::WR_BIT];
            pend_addr       <= pins_s.acc[pic_pkg::ADDR_LSB +: pic_pkg::ADDR_W];
            // Available means powered and the delay loop idle
            t4_avail        <= sel_now && !pins_s.prio && pins_s.power && !busy;
        end
    end

    assign drive_toward_peripheral_bus  = device_selected && is_write;
    assign drive_toward_accumulator_bus = device_selected && !is_write;

    // Register address: latched at T5, held through T1, cleared at T2
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reg_addr   <= '0;
            addr_valid <= 1'b0;
        end else if (enter_t2) begin
            reg_addr   <= '0;
            addr_valid <= 1'b0;
        end else if (enter_t5 && t4_avail) begin
            reg_addr   <= pend_addr;
            addr_valid <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            peripheral_data_strobe <= 1'b0;
        end else if (ce) begin
            peripheral_data_strobe <= (enter_t5 && t4_avail) || (enter_t1 && addr_valid);
        end
    end

    // The whole transfer lands at T1 of the same cycle
    assign spu_wr = enter_t1 && addr_valid && is_write;
    assign spu_rd = enter_t1 && addr_valid && !is_write;

    logic [ACC_W-1:0] spu_rdata;
    always_comb begin
        spu_rdata = '0;
        if (spu_hit(reg_addr, pic_pkg::SPU_MODE)) begin
            spu_rdata[pic_pkg::MODE_DMA]  = mode_dma;
            spu_rdata[pic_pkg::MODE_TRAP] = mode_trap;
        end else if (spu_hit(reg_addr, pic_pkg::SPU_STATUS)) begin
            spu_rdata[pic_pkg::STS_IRQ]   = irq_pending;
            spu_rdata[pic_pkg::STS_START] = start_request;
            spu_rdata[pic_pkg::STS_PHERR] = phase_err;
        end else if (spu_hit(reg_addr, pic_pkg::SPU_INSTR)) begin
            spu_rdata = instr;
        end else if (spu_hit(reg_addr, pic_pkg::SPU_STATION)) begin
            spu_rdata[pic_pkg::STATION_W-1:0] = station;
        end
    end

    // Accumulator bus drive: status at T4, read data at T1
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_bus_out <= '0;
            acc_bus_oe  <= '0;
        end else if (enter_t2 || enter_t5) begin
            acc_bus_out <= '0;
            acc_bus_oe  <= '0;
        end else if (enter_t4 && sel_now && !pins_s.prio) begin
            acc_bus_out <= {busy, irq_pending, mode_dma, pins_s.power, 20'h00000};
            acc_bus_oe  <= pic_pkg::STAT_OE;
        end else if (spu_rd) begin
            acc_bus_out <= spu_rdata;
            acc_bus_oe  <= {ACC_W{1'b1}};
        end
    end

    // AHB-Lite slave: always ready, always OKAY
    logic ahb_go;
    assign ahb_go    = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_ofs  <= '0;
            hrdata  <= '0;
        end else if (ce) begin
            wr_pend <= ahb_go && hwrite;
            wr_ofs  <= haddr[7:0];
            hrdata  <= '0;
            if (ahb_go && !hwrite) begin
                // Unmapped offsets read as zero
                case (haddr[7:0])
                    pic_pkg::OFS_MODE:    hrdata <= {30'h00000000, mode_trap, mode_dma};
                    pic_pkg::OFS_STATUS:  hrdata <= {29'h00000000, phase_err, start_request, irq_pending};
                    pic_pkg::OFS_STATION: hrdata <= {19'h00000, station};
                    pic_pkg::OFS_INSTR:   hrdata <= {8'h00, instr};
                    pic_pkg::OFS_XDL:     hrdata <= {16'h0000, xdl_delay};
                    pic_pkg::OFS_STATE:   hrdata <= {16'h0000, busy, device_selected, addr_valid,
                                                     reg_addr, state, 1'b0};
                    default:              hrdata <= '0;
                endcase
            end
        end
    end

    logic ahb_wr;
    assign ahb_wr = ce && wr_pend;

    // Short registers; a host transfer wins over a software write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_dma    <= 1'b0;
            mode_trap   <= 1'b0;
            irq_pending <= 1'b0;
            station     <= pic_pkg::STATION_RST;
            instr       <= '0;
            xdl_delay   <= pic_pkg::XDL_DELAY_RST;
        end else if (spu_wr) begin
            if (spu_hit(reg_addr, pic_pkg::SPU_MODE)) begin
                mode_dma  <= pins_s.acc[pic_pkg::MODE_DMA];
                mode_trap <= pins_s.acc[pic_pkg::MODE_TRAP];
            end
            if (spu_hit(reg_addr, pic_pkg::SPU_STATUS)) begin
                irq_pending <= pins_s.acc[pic_pkg::STS_IRQ];
            end
            if (spu_hit(reg_addr, pic_pkg::SPU_INSTR)) begin
                instr <= pins_s.acc;
            end
            if (spu_hit(reg_addr, pic_pkg::SPU_STATION)) begin
                station <= pins_s.acc[pic_pkg::STATION_W-1:0];
            end
        end else if (ahb_wr) begin
            if (ahb_hit(wr_ofs, pic_pkg::OFS_MODE)) begin
                mode_dma  <= hwdata[pic_pkg::MODE_DMA];
                mode_trap <= hwdata[pic_pkg::MODE_TRAP];
            end
            if (ahb_hit(wr_ofs, pic_pkg::OFS_STATUS)) begin
                irq_pending <= hwdata[pic_pkg::STS_IRQ];
            end
            if (ahb_hit(wr_ofs, pic_pkg::OFS_INSTR)) begin
                instr <= hwdata[ACC_W-1:0];
            end
            if (ahb_hit(wr_ofs, pic_pkg::OFS_XDL)) begin
                xdl_delay <= hwdata[pic_pkg::XDL_W-1:0];
            end
        end
    end

    // Start request: a press in the clearing cycle is not lost
    logic start_edge;
    assign start_edge = pins_s.start && !start_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_q       <= 1'b0;
            start_request <= 1'b0;
        end else if (ce) begin
            start_q <= pins_s.start;
            if (start_edge) begin
                start_request <= 1'b1;
            end else if (spu_rd && spu_hit(reg_addr, pic_pkg::SPU_STATION)) begin
                start_request <= 1'b0;
            end
        end
    end

    // Sticky phase order fault, software clears by writing one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_err <= 1'b0;
        end else if (ce) begin
            if (order_err) begin
                phase_err <= 1'b1;
            end else if (ahb_wr && ahb_hit(wr_ofs, pic_pkg::OFS_STATUS) && hwdata[pic_pkg::STS_PHERR]) begin
                phase_err <= 1'b0;
            end
        end
    end

    logic xdl_start;
    assign xdl_start = (spu_wr && spu_hit(reg_addr, pic_pkg::SPU_INSTR))
                    || (ahb_wr && ahb_hit(wr_ofs, pic_pkg::OFS_INSTR));

    pic_xdl #(
        .W (pic_pkg::XDL_W)
    ) u_xdl (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .start   (xdl_start),
        .delay   (xdl_delay),
        .busy    (busy)
    );

    // Checks
    a_phase_order: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == pic_pkg::ST_T1) && (next_state != pic_pkg::ST_T1) && ce
        |=> (state == pic_pkg::ST_T2) || (state == pic_pkg::ST_WAIT))
        else $error("phase after T1 was not T2");

    a_strobe_phase: assert property (@(posedge hclk) disable iff (!hresetn)
        peripheral_data_strobe |-> (state == pic_pkg::ST_T5) || (state == pic_pkg::ST_T1))
        else $error("data strobe outside T5 or T1");

    a_addr_cleared: assert property (@(posedge hclk) disable iff (!hresetn)
        enter_t2 |=> !addr_valid && (reg_addr == 6'h00))
        else $error("register address not cleared at T2");

    a_match_pair: assert property (@(posedge hclk) disable iff (!hresetn)
        device_code_match_a == device_code_match_b)
        else $error("device code matches disagree");

    a_select_and: assert property (@(posedge hclk) disable iff (!hresetn)
        enter_t4 |=> device_selected == $past(sel_now))
        else $error("device select not match AND select");

    a_status_drive: assert property (@(posedge hclk) disable iff (!hresetn)
        enter_t4 && sel_now && !pins_s.prio
        |=> (acc_bus_oe == pic_pkg::STAT_OE) && (acc_bus_out[20] == $past(pins_s.power)))
        else $error("status not driven on bits 20 to 23");

    a_dir_onehot: assert property (@(posedge hclk) disable iff (!hresetn)
        (drive_toward_peripheral_bus + drive_toward_accumulator_bus) == {1'b0, device_selected})
        else $error("direction enables not exclusive");

    a_start_held: assert property (@(posedge hclk) disable iff (!hresetn)
        start_request && ce && !spu_rd |=> start_request)
        else $error("start request dropped before read");

    a_busy_bit: assert property (@(posedge hclk) disable iff (!hresetn)
        xdl_start && (xdl_delay != '0) |=> busy [*2])
        else $error("delay loop busy not raised");

    a_strobe_avail: assert property (@(posedge hclk) disable iff (!hresetn)
        peripheral_data_strobe && (state == pic_pkg::ST_T5) |-> t4_avail)
        else $error("strobe at T5 without availability");

    a_addr_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == pic_pkg::ST_T5) ##1 (state == pic_pkg::ST_T1) |-> $stable(reg_addr))
        else $error("register address changed before T2");

endmodule : pic_core

// ### tb/pic_host.sv
// Host computer model: steps the phase lines and runs single transfers.
// Assumes the device drives the accumulator bus only where its enables are high.
`timescale 1ns/100ps
module pic_host (
    input  wire logic          hclk,
    input  wire logic          prio,
    input  wire logic          power,
    input  wire logic          start,
    input  wire logic [23:0]   acc_out,
    input  wire logic [23:0]   acc_oe,
    output pic_pkg::pic_pins_t pins
);
    logic [4:0]  phase = 5'h00;
    logic        psel  = 1'h0;
    logic        drv   = 1'h0;
    logic [23:0] hd    = 24'h000000;
    logic [23:0] hv    = 24'h000000;
    // Released bus toggles so a stale word never reads as valid
    always @(posedge hclk) hv <= ~hv;
    assign pins = '{phase, psel, prio, power, start, (acc_oe & acc_out) | (~acc_oe & (drv ? hd : hv))};
    task single_peripheral_transfer(input logic [13:0] ia, input logic wr, input logic [23:0] wd,
             output logic [23:0] st, output logic [23:0] rd);
        for (int i = 0; i < 5; i++) begin
            phase <= 5'h01 << i;
            psel  <= (i == 2);
            drv   <= (i == 2) || (i == 4 && wr);
            hd    <= (i == 2) ? {6'h33, 1'h0, wr, 2'h0, ia} : wd;
            repeat (6) @(posedge hclk);
            if (i == 2) st = pins.acc;
            if (i == 4) rd = pins.acc;
        end
    endtask : single_peripheral_transfer
endmodule : pic_host

// ### tb/tb_peripheral_instruction_cycle.sv
// Bench for the peripheral instruction cycle core: AHB-Lite master and host model.
// Assumes the core answers AHB with zero waits and the host model paces phases.
`timescale 1ns/100ps
module tb_peripheral_instruction_cycle;
    logic               hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, prio = 0, power = 1, start = 0, ce = 1;
    logic [1:0]         htrans = 0;
    logic [31:0]        haddr = 0, hwdata = 0, hrdata, r;
    logic               hreadyout, hresp, ma, mb, dsel, dtp, dta, stb;
    logic [23:0]        ao, aoe, st, rd, v;
    pic_pkg::pic_pins_t pins;
    int                 n_errors = 0, tests_run = 0, ns = 0, na = 0, np = 0;
    localparam logic [7:0] DC = pic_pkg::DEVICE_CODE_DEF;
    always #4 hclk = ~hclk;
    pic_core u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .host_pins(pins), .acc_bus_out(ao), .acc_bus_oe(aoe),
        .device_code_match_a(ma), .device_code_match_b(mb), .device_selected(dsel),
        .drive_toward_peripheral_bus(dtp), .drive_toward_accumulator_bus(dta), .peripheral_data_strobe(stb));
    pic_host u_host (.hclk(hclk), .prio(prio), .power(power), .start(start), .acc_out(ao), .acc_oe(aoe), .pins(pins));
    always @(posedge hclk) begin
        ns <= ns + stb;
        // Count directions only at strobes: selection lingers until the next T2
        na <= na + (stb & dta);
        np <= np + (stb & dtp);
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task results;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    task hwait;
        int k;
        k = 0;
        @(posedge hclk);
        while (hreadyout !== 1'h1) begin
            if (++k > 50) begin
                n_errors++;
                results;
            end
            @(posedge hclk);
        end
    endtask : hwait
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1; htrans <= 2'h2; haddr <= {24'h000000, a}; hwrite <= w;
        hwait;
        hsel <= 0; htrans <= 2'h0; hwdata <= wd;
        hwait;
        r = hrdata;
    endtask : ahb
    task xfer(input logic [7:0] c, input logic [5:0] ra, input logic wr, input logic [23:0] wd,
              input logic [3:0] es, input int e);
        int s0, a0, p0;
        s0 = ns; a0 = na; p0 = np;
        u_host.single_peripheral_transfer({ra, c}, wr, wd, st, rd);
        if (es !== 4'hX) chk(st[23:20], es);
        chk(ns - s0, e);
        if (e > 0) chk({na > a0, np > p0}, {!wr, wr});
        chk(dsel, c == DC);
    endtask : xfer
    initial begin
        v = $urandom(32'hD91B5170);
        repeat (20) @(posedge hclk);
        hresetn <= 1;
        ahb(0, pic_pkg::OFS_XDL, 0); chk(r, 32'h40);
        ahb(0, 8'h40, 0); chk(r, 0);
        chk(hresp, 0);
        ahb(1, pic_pkg::OFS_XDL, 4);
        start <= 1; repeat (4) @(posedge hclk); start <= 0; repeat (4) @(posedge hclk);
        ahb(0, pic_pkg::OFS_STATUS, 0); chk(r[1], 1);
        xfer(DC, pic_pkg::SPU_STATION, 0, 0, 4'h1, 2); chk(rd, 0);
        ahb(0, pic_pkg::OFS_STATUS, 0); chk(r[1], 0);
        // Frozen clock enable: a press while stopped must not be seen
        ce <= 0; start <= 1; repeat (4) @(posedge hclk); start <= 0; repeat (4) @(posedge hclk); ce <= 1;
        ahb(0, pic_pkg::OFS_STATUS, 0); chk(r[1], 0);
        $display("test start request done");
        repeat (3) begin
            v = $urandom;
            xfer(DC, pic_pkg::SPU_STATION, 1, v, 4'h1, 2);
            xfer(DC, pic_pkg::SPU_STATION, 0, 0, 4'h1, 2); chk(rd, {11'h000, v[12:0]});
            xfer(DC, pic_pkg::SPU_INSTR, 1, ~v, 4'h1, 2);
            ahb(0, pic_pkg::OFS_INSTR, 0); chk(r, {8'h00, ~v});
        end
        $display("test random transfers done");
        ahb(1, pic_pkg::OFS_MODE, 2); ahb(1, pic_pkg::OFS_MODE, 3);
        xfer(DC, pic_pkg::SPU_MODE, 0, 0, 4'h3, 2); chk(rd, 3);
        ahb(1, pic_pkg::OFS_MODE, 0); ahb(1, pic_pkg::OFS_STATUS, 1);
        xfer(DC, pic_pkg::SPU_STATUS, 0, 0, 4'h5, 2); chk(rd, 1);
        ahb(1, pic_pkg::OFS_STATUS, 0);
        $display("test status bits done");
        ahb(1, pic_pkg::OFS_XDL, 32'h40); ahb(1, pic_pkg::OFS_INSTR, 1);
        xfer(DC, pic_pkg::SPU_MODE, 0, 0, 4'h9, 0);
        repeat (80) @(posedge hclk);
        power <= 0;
        xfer(DC, pic_pkg::SPU_MODE, 0, 0, 4'h0, 0);
        power <= 1; prio <= 1;
        // Undriven status bits show the host's own instruction bits 23:20
        xfer(DC, pic_pkg::SPU_MODE, 0, 0, 4'hC, 0);
        prio <= 0;
        xfer(DC ^ 8'h01, pic_pkg::SPU_MODE, 0, 0, 4'hC, 0);
        $display("test refusals done");
        results;
    end
endmodule : tb_peripheral_instruction_cycle
